// [rtl/fprc_pkg.sv]
// fprc_pkg: constants and types shared by the rounding-control block.
// assumes a single core clock domain; no software-visible registers.
package fprc_pkg;
  // rounding-control field codes
  typedef enum logic [1:0] {
    FPRC_RND_NEAR  = 2'b00,  // nearest, ties to even (default)
    FPRC_RND_DOWN  = 2'b01,  // toward minus infinity
    FPRC_RND_UP    = 2'b10,  // toward plus infinity
    FPRC_RND_ZERO  = 2'b11   // toward zero (truncate)
  } fprc_mode_t;

  // destination formats
  typedef enum logic [1:0] {
    FPRC_FMT_SINGLE = 2'b00,
    FPRC_FMT_DOUBLE = 2'b01,
    FPRC_FMT_EXT    = 2'b10,
    FPRC_FMT_HALF   = 2'b11
  } fprc_fmt_t;

  // operation classes issued by the pipeline
  typedef enum logic [2:0] {
    FPRC_OP_ARITH   = 3'b000,  // ordinary arithmetic, rounded
    FPRC_OP_COMPARE = 3'b001,  // comparison, never rounded
    FPRC_OP_TRUNC   = 3'b010,  // truncating float-to-integer convert
    FPRC_OP_H2S     = 3'b011,  // half_to_single_convert
    FPRC_OP_S2H     = 3'b100,  // single_to_half_convert
    FPRC_OP_CONVERT = 3'b101   // other conversions, rounded
  } fprc_op_t;

  localparam int FPRC_SIG_W    = 64;  // significand width carried in
  localparam int FPRC_EXP_W    = 16;  // exponent width carried in
  localparam int FPRC_RES_W    = 80;  // widest result (extended)
  localparam int FPRC_X87_RC_LO  = 10;  // rounding field in scalar control word
  localparam int FPRC_SIMD_RC_LO = 13;  // rounding field in simd_fp_control_status
  localparam int FPRC_X87_CW_W   = 16;
  localparam int FPRC_SIMD_CS_W  = 32;

  // quiet-NaN indefinite encodings: sign set, max exponent, top fraction bit set
  localparam logic [FPRC_RES_W-1:0] FPRC_INDEF_SINGLE = 80'h0000_0000_0000_ffc0_0000;
  localparam logic [FPRC_RES_W-1:0] FPRC_INDEF_DOUBLE = 80'h0000_fff8_0000_0000_0000;
  localparam logic [FPRC_RES_W-1:0] FPRC_INDEF_EXT    = 80'hffff_c000_0000_0000_0000;
  localparam logic [FPRC_RES_W-1:0] FPRC_INDEF_HALF   = 80'h0000_0000_0000_0000_fe00;
endpackage

// [rtl/fprc_rnd_if.sv]
// fprc_rnd_if: carries one rounding decision between the top and the rounder.
// assumes both ends share the core clock.
`timescale 1ns/1ps
`default_nettype none
interface fprc_rnd_if;
  logic [fprc_pkg::FPRC_SIG_W-1:0] kept;     // significand after cut
  logic                            guard;    // first discarded bit
  logic                            sticky;   // or of the rest
  logic                            sign;     // sign of exact result
  fprc_pkg::fprc_mode_t            mode;     // effective rounding mode
  logic                            incr;     // add one ulp to kept
  logic                            inexact;  // some bit discarded
  modport top (output kept, guard, sticky, sign, mode, input incr, inexact);
  modport rnd (input kept, guard, sticky, sign, mode, output incr, inexact);
endinterface
`default_nettype wire

// [rtl/fprc_rounder.sv]
// fprc_rounder: picks between the two bracketing neighbours of an exact value.
// assumes the caller has aligned the significand and gathered guard and sticky.
`timescale 1ns/1ps
`default_nettype none
module fprc_rounder (
  fprc_rnd_if.rnd r  // rounding request and decision
);
  // neighbour choice per mode; no discarded bits means no change
  always_comb begin
    r.inexact = r.guard | r.sticky;  // RQ3
    case (r.mode)
      fprc_pkg::FPRC_RND_NEAR: r.incr = r.guard & (r.sticky | r.kept[0]);  // RQ5
      fprc_pkg::FPRC_RND_DOWN: r.incr = r.sign & r.inexact;                // RQ6
      fprc_pkg::FPRC_RND_UP:   r.incr = ~r.sign & r.inexact;               // RQ7
      fprc_pkg::FPRC_RND_ZERO: r.incr = 1'b0;                              // RQ8
      default:                 r.incr = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// [rtl/fprc_round_ctrl.sv]
// fprc_round_ctrl: rounding stage for the scalar stack unit and the simd unit.
// assumes the pipeline hands in an exact significand with guard and sticky bits.
// Function
// RQ1: return reserved quiet-NaN indefinite when asked
// RQ2: half precision only for two conversions
// RQ3: exact results pass; else choose bracketing neighbour
// RQ4: rounding error stays below one ulp
// RQ5: code 00 nearest, ties to even
// RQ6: code 01 toward minus infinity
// RQ7: code 10 toward plus infinity
// RQ8: code 11 toward zero
// RQ9: inexact result sets precision flag
// RQ10: compares, exact and NaN results ignore mode
// RQ11: mode is a two-bit field
// RQ12: scalar field at control bits 10-11
// RQ13: simd field at status bits 13-14
// RQ14: each field governs only its own unit
// RQ15: truncating converts always round toward zero
// RQ16: indefinite has top fraction bit set
// RQ17: precision flags sticky until software clears
`timescale 1ns/1ps
`default_nettype none
module fprc_round_ctrl #(
  parameter int SIG_W = fprc_pkg::FPRC_SIG_W  // significand width
) (
  input  wire logic                                  mclk,            // core clock
  input  wire logic                                  nrst,            // sync reset, low
  input  wire logic [fprc_pkg::FPRC_X87_CW_W-1:0]    scalar_ctrl,     // scalar control word
  input  wire logic [fprc_pkg::FPRC_SIMD_CS_W-1:0]   simd_fp_control_status, // simd control
  input  wire logic                                  op_valid,        // operation issued
  input  wire logic                                  op_simd,         // 1 simd, 0 scalar
  input  wire fprc_pkg::fprc_op_t                    op_kind,         // operation class
  input  wire fprc_pkg::fprc_fmt_t                   op_fmt,          // destination format
  input  wire logic                                  op_sign,         // exact sign
  input  wire logic [SIG_W-1:0]                      op_sig,          // kept significand
  input  wire logic                                  op_guard,        // first dropped bit
  input  wire logic                                  op_sticky,       // rest dropped bits
  input  wire logic                                  op_nan,          // result is NaN
  input  wire logic                                  op_indef,        // masked exception
  input  wire logic                                  scalar_flag_clr, // software clears
  input  wire logic                                  simd_flag_clr,   // software clears
  output logic                                       res_valid,       // result ready
  output logic [SIG_W-1:0]                           res_sig,         // rounded significand
  output logic                                       res_carry,       // significand overflowed
  output logic                                       res_indef,       // result is indefinite
  output logic [fprc_pkg::FPRC_RES_W-1:0]            res_indef_val,   // indefinite encoding
  output logic                                       res_inexact,     // this result rounded
  output logic                                       res_illegal,     // half arith refused
  output logic                                       scalar_precision_flag, // sticky
  output logic                                       simd_precision_flag    // sticky
);
  fprc_rnd_if ri ();  // channel to the rounder

  localparam int RC_W = $bits(fprc_pkg::fprc_mode_t);  // rounding field width, from the mode type

  // field extraction per unit
  fprc_pkg::fprc_mode_t scalar_mode;  // scalar field
  fprc_pkg::fprc_mode_t simd_mode;    // simd field
  fprc_pkg::fprc_mode_t eff_mode;     // mode actually used
  logic                 half_bad;     // half used for arithmetic
  logic                 no_round;     // compare or NaN: pass through
  logic                 indef_now;    // indefinite delivered
  logic                 inexact_now;  // rounded this cycle
  logic [SIG_W:0]       sum;          // kept plus increment

  // two-bit fields picked from their own control words
  assign scalar_mode = fprc_pkg::fprc_mode_t'(scalar_ctrl[fprc_pkg::FPRC_X87_RC_LO +: RC_W]);  // RQ12 RQ11
  assign simd_mode   = fprc_pkg::fprc_mode_t'(simd_fp_control_status[fprc_pkg::FPRC_SIMD_RC_LO +: RC_W]);  // RQ13

  // mode selection: unit field, overridden by truncating converts
  always_comb begin
    if (op_kind == fprc_pkg::FPRC_OP_TRUNC) begin
      eff_mode = fprc_pkg::FPRC_RND_ZERO;  // RQ15
    end else if (op_simd) begin
      eff_mode = simd_mode;  // RQ14
    end else begin
      eff_mode = scalar_mode;  // RQ14
    end
  end

  // half format allowed only as a conversion end
  assign half_bad = (op_fmt == fprc_pkg::FPRC_FMT_HALF) &&
                    (op_kind != fprc_pkg::FPRC_OP_S2H) && (op_kind != fprc_pkg::FPRC_OP_H2S);  // RQ2

  // compares and NaN results never round
  assign no_round  = (op_kind == fprc_pkg::FPRC_OP_COMPARE) | op_nan;  // RQ10
  assign indef_now = op_indef & ~half_bad;  // RQ1

  assign ri.kept   = op_sig;
  assign ri.guard  = op_guard & ~no_round;
  assign ri.sticky = op_sticky & ~no_round;
  assign ri.sign   = op_sign;
  assign ri.mode   = eff_mode;

  fprc_rounder u_rnd (
    .r (ri)
  );

  // one-ulp step at most keeps error below one ulp
  assign sum = {1'b0, op_sig} + {{SIG_W{1'b0}}, ri.incr};  // RQ4
  assign inexact_now = op_valid & ri.inexact & ~indef_now & ~half_bad;  // RQ9

  // result register
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      res_valid   <= 1'b0;
      res_sig     <= '0;
      res_carry   <= 1'b0;
      res_indef   <= 1'b0;
      res_inexact <= 1'b0;
      res_illegal <= 1'b0;
    end else begin
      res_valid   <= op_valid;
      res_sig     <= sum[SIG_W-1:0];  // RQ3
      res_carry   <= sum[SIG_W];
      res_indef   <= op_valid & indef_now;  // RQ1
      res_inexact <= inexact_now;
      res_illegal <= op_valid & half_bad;  // RQ2
    end
  end

  // indefinite encoding per destination format
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      res_indef_val <= '0;
    end else begin
      case (op_fmt)
        fprc_pkg::FPRC_FMT_SINGLE: res_indef_val <= fprc_pkg::FPRC_INDEF_SINGLE;  // RQ16
        fprc_pkg::FPRC_FMT_DOUBLE: res_indef_val <= fprc_pkg::FPRC_INDEF_DOUBLE;
        fprc_pkg::FPRC_FMT_EXT:    res_indef_val <= fprc_pkg::FPRC_INDEF_EXT;
        default:                   res_indef_val <= fprc_pkg::FPRC_INDEF_HALF;
      endcase
    end
  end

  // sticky precision flags, set wins over clear
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      scalar_precision_flag <= 1'b0;
      simd_precision_flag   <= 1'b0;
    end else begin
      scalar_precision_flag <= (inexact_now & ~op_simd) | (scalar_precision_flag & ~scalar_flag_clr);  // RQ17 RQ14
      simd_precision_flag   <= (inexact_now & op_simd) | (simd_precision_flag & ~simd_flag_clr);  // RQ17
    end
  end

  // checks: latency and handshake
  a_valid_follows: assert property (@(posedge mclk) disable iff (!nrst)  // RQ3
    op_valid |=> res_valid)
    else $error("result valid missing one cycle after issue");
  a_idle_no_valid: assert property (@(posedge mclk) disable iff (!nrst)  // RQ9
    !op_valid |=> !res_valid && !res_inexact)
    else $error("result flagged without an issued operation");
  // checks: neighbour choice per mode
  a_trunc_no_incr: assert property (@(posedge mclk) disable iff (!nrst)  // RQ15
    op_valid && op_kind == fprc_pkg::FPRC_OP_TRUNC |=> res_sig == $past(op_sig) && !res_carry)
    else $error("truncating convert incremented");
  a_exact_passes: assert property (@(posedge mclk) disable iff (!nrst)  // RQ3
    op_valid && !op_guard && !op_sticky |=> res_sig == $past(op_sig) && !res_inexact)
    else $error("exact result altered");
  a_tie_to_even: assert property (@(posedge mclk) disable iff (!nrst)  // RQ5
    op_valid && !op_nan && op_kind == fprc_pkg::FPRC_OP_ARITH && !op_simd && scalar_mode == fprc_pkg::FPRC_RND_NEAR
    && op_guard && !op_sticky |=> res_sig[0] == 1'b0 || res_carry)
    else $error("tie not rounded to even");
  a_near_rounds_up: assert property (@(posedge mclk) disable iff (!nrst)  // RQ5
    op_valid && eff_mode == fprc_pkg::FPRC_RND_NEAR && !no_round && op_guard && op_sticky
    |=> {res_carry, res_sig} == {1'b0, $past(op_sig)} + {{SIG_W{1'b0}}, 1'b1})
    else $error("above half an ulp not rounded up");
  a_down_sign: assert property (@(posedge mclk) disable iff (!nrst)  // RQ6
    op_valid && eff_mode == fprc_pkg::FPRC_RND_DOWN && !op_sign |=> res_sig == $past(op_sig))
    else $error("round down grew positive value");
  a_up_sign: assert property (@(posedge mclk) disable iff (!nrst)  // RQ7
    op_valid && eff_mode == fprc_pkg::FPRC_RND_UP && op_sign |=> res_sig == $past(op_sig))
    else $error("round up grew negative magnitude");
  a_nan_no_round: assert property (@(posedge mclk) disable iff (!nrst)  // RQ10
    op_valid && op_nan |=> !res_inexact && res_sig == $past(op_sig))
    else $error("nan result rounded");
  a_compare_exact: assert property (@(posedge mclk) disable iff (!nrst)  // RQ10
    op_valid && op_kind == fprc_pkg::FPRC_OP_COMPARE |=> !res_inexact && res_sig == $past(op_sig))
    else $error("compare result rounded");
  // checks: sticky flags per unit
  a_flag_sticky: assert property (@(posedge mclk) disable iff (!nrst)  // RQ17
    simd_precision_flag && !simd_flag_clr |=> simd_precision_flag)
    else $error("simd precision flag lost");
  a_scalar_sticky: assert property (@(posedge mclk) disable iff (!nrst)  // RQ17
    scalar_precision_flag && !scalar_flag_clr |=> scalar_precision_flag)
    else $error("scalar precision flag lost");
  a_set_beats_clear: assert property (@(posedge mclk) disable iff (!nrst)  // RQ17
    op_valid && !op_simd && inexact_now && scalar_flag_clr |=> scalar_precision_flag)
    else $error("clear beat a same-cycle scalar set");
  a_flag_unit: assert property (@(posedge mclk) disable iff (!nrst)  // RQ9
    res_inexact && !$past(op_simd) && !$past(scalar_precision_flag) |-> scalar_precision_flag)
    else $error("scalar precision flag not set");
  a_simd_flag_set: assert property (@(posedge mclk) disable iff (!nrst)  // RQ9
    res_inexact && $past(op_simd) |-> simd_precision_flag)
    else $error("simd precision flag not set");
  a_scalar_isolated: assert property (@(posedge mclk) disable iff (!nrst)  // RQ14
    op_valid && op_simd && !scalar_flag_clr && !scalar_precision_flag |=> !scalar_precision_flag)
    else $error("simd operation set scalar flag");
  a_simd_isolated: assert property (@(posedge mclk) disable iff (!nrst)  // RQ14
    op_valid && !op_simd && !simd_flag_clr && !simd_precision_flag |=> !simd_precision_flag)
    else $error("scalar operation set simd flag");
  // checks: half format and indefinite encodings
  a_half_refused: assert property (@(posedge mclk) disable iff (!nrst)  // RQ2
    op_valid && op_fmt == fprc_pkg::FPRC_FMT_HALF && op_kind == fprc_pkg::FPRC_OP_ARITH |=> res_illegal && !res_inexact)
    else $error("half arithmetic accepted");
  a_half_conv_ok: assert property (@(posedge mclk) disable iff (!nrst)  // RQ2
    op_valid && (op_kind == fprc_pkg::FPRC_OP_H2S || op_kind == fprc_pkg::FPRC_OP_S2H) |=> !res_illegal)
    else $error("half conversion refused");
  a_indef_quiet: assert property (@(posedge mclk) disable iff (!nrst)  // RQ16
    res_indef && $past(op_fmt) == fprc_pkg::FPRC_FMT_SINGLE |-> res_indef_val[22])
    else $error("indefinite not quiet");
  a_indef_double: assert property (@(posedge mclk) disable iff (!nrst)  // RQ1
    res_indef && $past(op_fmt) == fprc_pkg::FPRC_FMT_DOUBLE |-> res_indef_val == fprc_pkg::FPRC_INDEF_DOUBLE)
    else $error("double indefinite encoding wrong");
  a_indef_ext: assert property (@(posedge mclk) disable iff (!nrst)  // RQ1
    res_indef && $past(op_fmt) == fprc_pkg::FPRC_FMT_EXT |-> res_indef_val == fprc_pkg::FPRC_INDEF_EXT)
    else $error("extended indefinite encoding wrong");
  a_indef_half: assert property (@(posedge mclk) disable iff (!nrst)  // RQ1
    res_indef && $past(op_fmt) == fprc_pkg::FPRC_FMT_HALF |-> res_indef_val == fprc_pkg::FPRC_INDEF_HALF)
    else $error("half indefinite encoding wrong");
endmodule
`default_nettype wire

// [testbench/fprc_pipe_model.sv]
// fprc_pipe_model: stands in for the execution pipeline that issues operations.
// assumes the bench calls issue and idle right after a rising mclk edge.
`timescale 1ns/1ps
`default_nettype none
module fprc_pipe_model (
  input  wire logic              mclk,      // core clock
  output var  logic              op_valid,  // operation present
  output var  logic              op_simd,   // unit select
  output var  fprc_pkg::fprc_op_t  op_kind, // operation class
  output var  fprc_pkg::fprc_fmt_t op_fmt,  // destination format
  output var  logic              op_sign,   // exact sign
  output var  logic [63:0]       op_sig,    // kept significand
  output var  logic              op_guard,  // first dropped bit
  output var  logic              op_sticky, // rest dropped bits
  output var  logic              op_nan,    // nan result
  output var  logic              op_indef   // masked exception
);
  // idle values at time zero
  initial begin
    {op_valid, op_simd, op_sign, op_guard, op_sticky, op_nan, op_indef} = 7'h00;
    op_kind = fprc_pkg::FPRC_OP_ARITH;
    op_fmt  = fprc_pkg::FPRC_FMT_SINGLE;
    op_sig  = 64'h0;
  end
  // present one operation from this edge on
  task automatic issue(input logic [2:0] k, input logic [1:0] f, input logic sm, sn,
                       input logic [63:0] sg, input logic g, st, nn, ix);
    op_valid  <= 1'b1;
    op_kind   <= fprc_pkg::fprc_op_t'(k);
    op_fmt    <= fprc_pkg::fprc_fmt_t'(f);
    op_simd   <= sm;
    op_sign   <= sn;
    op_sig    <= sg;
    op_guard  <= g;
    op_sticky <= st;
    op_nan    <= nn;
    op_indef  <= ix;
  endtask
  // drop valid; stale significand, guard and sticky are inverted so nothing leans on them
  task automatic idle();
    op_valid  <= 1'b0;
    op_sig    <= ~op_sig;
    op_guard  <= ~op_guard;
    op_sticky <= ~op_sticky;
  endtask
endmodule
`default_nettype wire

// [testbench/tb_fp_rounding_control.sv]
// tb_fp_rounding_control: random and corner-case checks of the rounding stage.
// assumes one 100 MHz clock and a result exactly one cycle after each issue.
`timescale 1ns/1ps
`default_nettype none
module tb_fp_rounding_control;
  logic mclk, nrst, op_valid, op_simd, op_sign, op_guard, op_sticky, op_nan, op_indef;
  logic scalar_flag_clr, simd_flag_clr, res_valid, res_carry, res_indef, res_inexact, res_illegal;
  logic scalar_precision_flag, simd_precision_flag;
  logic [15:0] scalar_ctrl;             // scalar control word
  logic [31:0] simd_fp_control_status;  // simd control word
  logic [63:0] op_sig, res_sig;         // significands
  logic [79:0] res_indef_val;           // indefinite encoding
  fprc_pkg::fprc_op_t  op_kind;         // operation class
  fprc_pkg::fprc_fmt_t op_fmt;          // destination format
  int err_total = 0;                    // mismatches
  int num_checks = 0;                   // comparisons
  logic sf = 1'b0, vf = 1'b0;           // expected sticky flags

  fprc_round_ctrl DUT (.mclk(mclk), .nrst(nrst), .scalar_ctrl(scalar_ctrl),
    .simd_fp_control_status(simd_fp_control_status), .op_valid(op_valid), .op_simd(op_simd),
    .op_kind(op_kind), .op_fmt(op_fmt), .op_sign(op_sign), .op_sig(op_sig), .op_guard(op_guard),
    .op_sticky(op_sticky), .op_nan(op_nan), .op_indef(op_indef), .scalar_flag_clr(scalar_flag_clr),
    .simd_flag_clr(simd_flag_clr), .res_valid(res_valid), .res_sig(res_sig), .res_carry(res_carry),
    .res_indef(res_indef), .res_indef_val(res_indef_val), .res_inexact(res_inexact),
    .res_illegal(res_illegal), .scalar_precision_flag(scalar_precision_flag),
    .simd_precision_flag(simd_precision_flag));
  fprc_pipe_model pipe (.mclk(mclk), .op_valid(op_valid), .op_simd(op_simd), .op_kind(op_kind),
    .op_fmt(op_fmt), .op_sign(op_sign), .op_sig(op_sig), .op_guard(op_guard), .op_sticky(op_sticky),
    .op_nan(op_nan), .op_indef(op_indef));

  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // compare and count
  task automatic chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one operation: work out the answer, issue, then compare one cycle later
  task automatic run(input logic [2:0] k, input logic [1:0] f, input logic sm, sn, input logic [63:0] sg,
                     input logic g, st, nn, ix, input logic [15:0] cw, input logic [31:0] cs);
    logic [1:0] md;
    logic inx, inc, ill;
    logic [64:0] sum;
    logic [79:0] iv;
    ill = (f == 2'h3) && (k != 3'h3) && (k != 3'h4);
    md = (k == 3'h2) ? 2'h3 : (sm ? cs[14:13] : cw[11:10]);
    inx = (g | st) && (k != 3'h1) && !nn && !ill;
    case (md)
      2'h0: inc = g & (st | sg[0]);
      2'h1: inc = sn;
      2'h2: inc = !sn;
      default: inc = 1'b0;
    endcase
    inc = inc & inx;
    sum = {1'b0, sg} + 65'(inc);
    iv = (f == 2'h0) ? fprc_pkg::FPRC_INDEF_SINGLE : (f == 2'h1) ? fprc_pkg::FPRC_INDEF_DOUBLE :
         (f == 2'h2) ? fprc_pkg::FPRC_INDEF_EXT : fprc_pkg::FPRC_INDEF_HALF;
    @(posedge mclk);
    pipe.issue(k, f, sm, sn, sg, g, st, nn, ix);
    scalar_ctrl <= cw;
    simd_fp_control_status <= cs;
    @(posedge mclk);
    pipe.idle();
    if (inx && sm) vf = 1'b1;
    if (inx && !sm) sf = 1'b1;
    #1;
    chk("valid", 80'(res_valid), 80'h1);
    if (!ill) chk("sig", {15'h0, res_carry, res_sig}, 80'(sum));
    chk("inexact", 80'(res_inexact), 80'(inx));
    chk("illegal", 80'(res_illegal), 80'(ill));
    chk("indef", 80'(res_indef), 80'(ix && !ill));
    if (ix && !ill) chk("indefval", res_indef_val, iv);
    chk("flags", {78'h0, scalar_precision_flag, simd_precision_flag}, {78'h0, sf, vf});
  endtask

  // main sequence
  initial begin
    nrst = 1'b0;
    scalar_ctrl = 16'h0;
    simd_fp_control_status = 32'h0;
    scalar_flag_clr = 1'b0;
    simd_flag_clr = 1'b0;
    void'($urandom(88003));
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    #1;
    chk("reset", {77'h0, res_valid, scalar_precision_flag, simd_precision_flag}, 80'h0);
    // every mode code on each unit, both signs, exact tie; other unit's field inverted
    for (int i = 0; i < 16; i++) run(3'h0, 2'h0, i[3], i[0], 64'h3, 1'b1, 1'b0, 1'b0, 1'b0,
                                     i[3] ? ~(16'(i[2:1]) << 10) : 16'(i[2:1]) << 10,
                                     i[3] ? 32'(i[2:1]) << 13 : ~(32'(i[2:1]) << 13));
    run(3'h0, 2'h0, 1'b0, 1'b0, 64'h2, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0, 32'h0);
    run(3'h5, 2'h1, 1'b1, 1'b0, '1, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0, 32'h0);
    run(3'h2, 2'h0, 1'b1, 1'b0, 64'h5, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0, 32'h4000);
    for (int f = 0; f < 4; f++) run(3'h3, 2'(f), 1'b1, 1'b1, 64'h9, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0, 32'h0);
    run(3'h0, 2'h3, 1'b1, 1'b0, 64'h1, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0, 32'h0);
    // sticky clear of both flags
    @(posedge mclk);
    scalar_flag_clr <= 1'b1;
    simd_flag_clr <= 1'b1;
    @(posedge mclk);
    scalar_flag_clr <= 1'b0;
    simd_flag_clr <= 1'b0;
    sf = 1'b0;
    vf = 1'b0;
    @(posedge mclk);
    #1;
    chk("cleared", {78'h0, scalar_precision_flag, simd_precision_flag}, 80'h0);
    // set beats clear in one cycle, then the clear lands
    @(posedge mclk);
    scalar_flag_clr <= 1'b1;
    run(3'h0, 2'h0, 1'b0, 1'b0, 64'h1, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0, 32'h0);
    @(posedge mclk);
    scalar_flag_clr <= 1'b0;
    sf = 1'b0;
    // random traffic
    repeat (300) run(3'($urandom % 6), 2'($urandom % 3), 1'($urandom), 1'($urandom),
                     ($urandom % 8 == 0) ? '1 : {$urandom, $urandom}, 1'($urandom), 1'($urandom),
                     ($urandom % 8 == 0), 1'b0, 16'($urandom), $urandom);
    test_done();
  end
  // hang guard
  initial begin
    #100000;
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
